/* design/pirqvm_consts.svh */
// Constants for the peripheral interrupt vector map
// Contract
// - Vector offsets 0x00 to 0x3C belong to core exceptions, never peripheral lines.
// - Thirty-two user lines; line n vector word sits at 0x40 plus 4n.
// - Each used line is driven by exactly one peripheral interrupt output.
// - Reset, NMI, hard fault fixed at -3, -2, -1 in words 4, 8, 12.
// - Supervisor call, pendable service, system tick settable at 3, 5, 6.
// - GPIO 0, flash 1, UART 4, SPI 5, watchdog 7, ADC 13, I2C 14/15.
// - Lines 17-20 timer A/B requests, 21 RTC, 22 key accelerator, 23 DMA.
// - Line 6 carries the radio controller, critical class, vector 0x58.
`ifndef PIRQVM_CONSTS_SVH
`define PIRQVM_CONSTS_SVH

`define PIRQVM_NUM_LINES 32
`define PIRQVM_USER_FIRST_IDX 6'h10
`define PIRQVM_IDX_LIMIT 6'h30
`define PIRQVM_CORE_LAST_ADDR 8'h3c
`define PIRQVM_USER_BASE_ADDR 8'h40
`define PIRQVM_USER_LAST_ADDR 8'hbc
`define PIRQVM_RADIO_ADDR 8'h58
`define PIRQVM_RSVD_MASK 32'hff01_1f0c

`define PIRQVM_EXC_STACK 4'h0
`define PIRQVM_EXC_RESET 4'h1
`define PIRQVM_EXC_NMI 4'h2
`define PIRQVM_EXC_HARD_FAULT 4'h3
`define PIRQVM_EXC_SUPERVISOR_CALL 4'hb
`define PIRQVM_EXC_PENDSRV 4'he
`define PIRQVM_EXC_SYSTICK 4'hf

`define PIRQVM_PRIO_RESET 4'hd
`define PIRQVM_PRIO_NMI 4'he
`define PIRQVM_PRIO_HARD_FAULT 4'hf
`define PIRQVM_PRIO_SUPERVISOR_CALL 4'h3
`define PIRQVM_PRIO_PENDSRV 4'h5
`define PIRQVM_PRIO_SYSTICK 4'h6
`define PIRQVM_PRIO_USER_INIT 4'h0

`define PIRQVM_LN_GPIO 0
`define PIRQVM_LN_FLASH 1
`define PIRQVM_LN_UART 4
`define PIRQVM_LN_SPI 5
`define PIRQVM_LN_RADIO 6
`define PIRQVM_LN_WDOG 7
`define PIRQVM_LN_ADC 13
`define PIRQVM_LN_I2C2 14
`define PIRQVM_LN_I2C1 15
`define PIRQVM_LN_TIMER_ONE_A 17
`define PIRQVM_LN_TIMER_ONE_B 18
`define PIRQVM_LN_TIMER_TWO_A 19
`define PIRQVM_LN_TIMER_TWO_B 20
`define PIRQVM_LN_RTC 21
`define PIRQVM_LN_PKACC 22
`define PIRQVM_LN_DMA 23
`define PIRQVM_LN_RADIO_5 5'h06

`endif

/* design/pirqvm_pkg.sv */
// Types and helpers for the peripheral interrupt vector map
package pirqvm_pkg;
    typedef logic [5:0] pirqvm_idx_type;
    typedef logic [7:0] pirqvm_addr_type;
    typedef logic signed [3:0] pirqvm_prio_type;
    typedef enum logic [1:0] {
        PIRQVM_CLS_NONE = 2'h0,
        PIRQVM_CLS_FIXED = 2'h1,
        PIRQVM_CLS_SETTABLE = 2'h2,
        PIRQVM_CLS_CRITICAL = 2'h3
    } pirqvm_class_type;

    // Vector word offset of an exception position
    function automatic pirqvm_addr_type pirqvm_vec_addr(input pirqvm_idx_type idx);
        pirqvm_vec_addr = {idx, 2'h0};
    endfunction

    // User line number of a position at or above the user base
    function automatic logic [4:0] pirqvm_user_line(input pirqvm_idx_type idx);
        pirqvm_idx_type diff;
        diff = idx - 6'h10;
        pirqvm_user_line = diff[4:0];
    endfunction
endpackage

/* design/pirqvm_top.sv */
// Peripheral interrupt routing onto user lines and vector table lookup
`include "pirqvm_consts.svh"
module pirqvm_top
    import pirqvm_pkg::*;
(
    input wire logic clk_sys_i, // System clock, 10 MHz
    input wire logic srst_i, // Synchronous reset, active high
    input wire logic gpio_irq_i, // GPIO request
    input wire logic flash_irq_i, // Flash controller request
    input wire logic uart_irq_i, // UART request
    input wire logic spi_irq_i, // SPI request
    input wire logic radio_irq_i, // Radio link controller request
    input wire logic wdog_irq_i, // Watchdog request
    input wire logic adc_irq_i, // ADC request
    input wire logic i2c2_irq_i, // Second I2C request
    input wire logic i2c1_irq_i, // First I2C request
    input wire logic multifunction_timer_one_a_irq_i, // multifunction_timer_one A request
    input wire logic multifunction_timer_one_b_irq_i, // multifunction_timer_one B request
    input wire logic multifunction_timer_two_a_irq_i, // multifunction_timer_two A request
    input wire logic multifunction_timer_two_b_irq_i, // multifunction_timer_two B request
    input wire logic rtc_irq_i, // Real-time clock request
    input wire logic pkacc_irq_i, // public_key_accelerator request
    input wire logic dma_irq_i, // DMA controller request
    input wire logic vec_req_i, // Lookup strobe
    input wire pirqvm_idx_type vec_idx_i, // Vector position to look up
    output logic [31:0] user_irq_o, // Lines to nested_vector_irq_ctrl
    output logic crit_irq_o, // Critical radio line active
    output logic vec_valid_o, // Lookup answer valid
    output pirqvm_addr_type vec_addr_o, // Vector word offset
    output pirqvm_prio_type vec_prio_o, // Default priority
    output pirqvm_class_type vec_cls_o, // Priority class
    output logic vec_rsvd_o // Position reserved
);
    logic [31:0] irq_r;
    logic [31:0] irq_nxt;
    logic crit_r;
    logic crit_nxt;
    logic valid_r;
    logic valid_nxt;
    pirqvm_addr_type addr_r;
    pirqvm_addr_type addr_nxt;
    pirqvm_prio_type prio_r;
    pirqvm_prio_type prio_nxt;
    pirqvm_class_type cls_r;
    pirqvm_class_type cls_nxt;
    logic rsvd_r;
    logic rsvd_nxt;

    pirqvm_addr_type lk_addr;
    pirqvm_prio_type lk_prio;
    pirqvm_class_type lk_cls;
    logic lk_rsvd;

    pirqvm_vec_lookup u_lookup (
        .idx_i(vec_idx_i),
        .addr_o(lk_addr),
        .prio_o(lk_prio),
        .cls_o(lk_cls),
        .rsvd_o(lk_rsvd)
    );

    // Line routing
    always_comb begin
        irq_nxt = '0;
        irq_nxt[`PIRQVM_LN_GPIO] = gpio_irq_i;
        irq_nxt[`PIRQVM_LN_FLASH] = flash_irq_i;
        irq_nxt[`PIRQVM_LN_UART] = uart_irq_i;
        irq_nxt[`PIRQVM_LN_SPI] = spi_irq_i;
        irq_nxt[`PIRQVM_LN_WDOG] = wdog_irq_i;
        irq_nxt[`PIRQVM_LN_ADC] = adc_irq_i;
        irq_nxt[`PIRQVM_LN_I2C2] = i2c2_irq_i;
        irq_nxt[`PIRQVM_LN_I2C1] = i2c1_irq_i;
        irq_nxt[`PIRQVM_LN_RADIO] = radio_irq_i;
        irq_nxt[`PIRQVM_LN_TIMER_ONE_A] = multifunction_timer_one_a_irq_i;
        irq_nxt[`PIRQVM_LN_TIMER_ONE_B] = multifunction_timer_one_b_irq_i;
        irq_nxt[`PIRQVM_LN_TIMER_TWO_A] = multifunction_timer_two_a_irq_i;
        irq_nxt[`PIRQVM_LN_TIMER_TWO_B] = multifunction_timer_two_b_irq_i;
        irq_nxt[`PIRQVM_LN_RTC] = rtc_irq_i;
        irq_nxt[`PIRQVM_LN_PKACC] = pkacc_irq_i;
        irq_nxt[`PIRQVM_LN_DMA] = dma_irq_i;
        irq_nxt = irq_nxt & ~`PIRQVM_RSVD_MASK;
        crit_nxt = radio_irq_i;
        if (srst_i) begin
            irq_nxt = '0;
            crit_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        irq_r <= irq_nxt;
        crit_r <= crit_nxt;
    end

    // Lookup answer, one cycle after the strobe
    always_comb begin
        valid_nxt = vec_req_i;
        addr_nxt = addr_r;
        prio_nxt = prio_r;
        cls_nxt = cls_r;
        rsvd_nxt = rsvd_r;
        if (vec_req_i) begin
            addr_nxt = lk_addr;
            prio_nxt = lk_prio;
            cls_nxt = lk_cls;
            rsvd_nxt = lk_rsvd;
        end
        if (srst_i) begin
            valid_nxt = 1'b0;
            addr_nxt = '0;
            prio_nxt = '0;
            cls_nxt = PIRQVM_CLS_NONE;
            rsvd_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        valid_r <= valid_nxt;
        addr_r <= addr_nxt;
        prio_r <= prio_nxt;
        cls_r <= cls_nxt;
        rsvd_r <= rsvd_nxt;
    end

    assign user_irq_o = irq_r;
    assign crit_irq_o = crit_r;
    assign vec_valid_o = valid_r;
    assign vec_addr_o = addr_r;
    assign vec_prio_o = prio_r;
    assign vec_cls_o = cls_r;
    assign vec_rsvd_o = rsvd_r;

    // Checks
    sequence s_query(logic [5:0] pos);
        vec_req_i && !srst_i && vec_idx_i == pos;
    endsequence

    sequence s_core_query;
        vec_req_i && !srst_i && vec_idx_i < `PIRQVM_USER_FIRST_IDX;
    endsequence

    sequence s_user_query;
        vec_req_i && !srst_i && vec_idx_i >= `PIRQVM_USER_FIRST_IDX
            && vec_idx_i < `PIRQVM_IDX_LIMIT;
    endsequence

    chk_core_region: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        s_core_query |=> vec_valid_o && vec_addr_o <= `PIRQVM_CORE_LAST_ADDR
            && vec_cls_o != PIRQVM_CLS_CRITICAL)
        else $error("core vector outside core region");

    chk_user_offset: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        s_user_query |=> vec_addr_o >= `PIRQVM_USER_BASE_ADDR
            && vec_addr_o <= `PIRQVM_USER_LAST_ADDR
            && vec_addr_o == {$past(vec_idx_i), 2'h0})
        else $error("user vector offset wrong");

    chk_line_follow: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        !srst_i ##1 !srst_i |-> user_irq_o[`PIRQVM_LN_GPIO] == $past(gpio_irq_i)
            && user_irq_o[`PIRQVM_LN_DMA] == $past(dma_irq_i))
        else $error("line does not follow its peripheral");

    chk_fixed_prio: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        s_query(6'h01) ##1 s_query(6'h02) ##1 s_query(6'h03)
        |=> $past(vec_prio_o, 2) == `PIRQVM_PRIO_RESET
            && $past(vec_prio_o) == `PIRQVM_PRIO_NMI
            && vec_prio_o == `PIRQVM_PRIO_HARD_FAULT
            && vec_cls_o == PIRQVM_CLS_FIXED && vec_addr_o == 8'h0c)
        else $error("fixed core priority wrong");

    chk_settable_core: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        s_query(6'h0e) |=> vec_prio_o == `PIRQVM_PRIO_PENDSRV
            && vec_cls_o == PIRQVM_CLS_SETTABLE && vec_addr_o == 8'h38)
        else $error("pendable service entry wrong");

    chk_base_map: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        uart_irq_i && !spi_irq_i && !srst_i |=> user_irq_o[`PIRQVM_LN_UART]
            && !user_irq_o[`PIRQVM_LN_SPI])
        else $error("UART or SPI line misrouted");

    chk_timer_map: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        multifunction_timer_two_b_irq_i && !rtc_irq_i && !srst_i
            |=> user_irq_o[`PIRQVM_LN_TIMER_TWO_B] && !user_irq_o[`PIRQVM_LN_RTC])
        else $error("timer or clock line misrouted");

    chk_radio_crit: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        s_query(6'h16) |=> vec_cls_o == PIRQVM_CLS_CRITICAL
            && vec_addr_o == `PIRQVM_RADIO_ADDR)
        else $error("radio vector not critical");

    chk_radio_line: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        radio_irq_i && !srst_i |=> crit_irq_o && user_irq_o[`PIRQVM_LN_RADIO])
        else $error("radio request not on critical line");

    chk_rsvd_quiet: assert property (
        @(posedge clk_sys_i)
        (user_irq_o & `PIRQVM_RSVD_MASK) == 32'h0000_0000)
        else $error("reserved line raised");

    chk_rsvd_flag: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        s_query(6'h28) ##1 s_query(6'h2f) |=> vec_rsvd_o && $past(vec_rsvd_o))
        else $error("reserved line not flagged");

    chk_valid_pulse: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        vec_req_i |=> vec_valid_o)
        else $error("strobe without answer");

    chk_answer_hold: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        !vec_req_i |=> !vec_valid_o && $stable(vec_addr_o) && $stable(vec_cls_o))
        else $error("answer changed without a strobe");
endmodule

/* design/pirqvm_vec_lookup.sv */
// Vector table lookup: position to offset, priority and class
`include "pirqvm_consts.svh"
module pirqvm_vec_lookup
    import pirqvm_pkg::*;
(
    input wire pirqvm_idx_type idx_i, // Vector position
    output pirqvm_addr_type addr_o, // Vector word offset
    output pirqvm_prio_type prio_o, // Default priority
    output pirqvm_class_type cls_o, // Priority class
    output logic rsvd_o // Position reserved or out of table
);
    logic [4:0] line;
    logic [31:0] rsvd_mask;

    assign line = pirqvm_user_line(idx_i);
    assign rsvd_mask = `PIRQVM_RSVD_MASK;

    always_comb begin
        addr_o = pirqvm_vec_addr(idx_i);
        prio_o = `PIRQVM_PRIO_USER_INIT;
        cls_o = PIRQVM_CLS_NONE;
        rsvd_o = 1'b0;
        if (idx_i < `PIRQVM_USER_FIRST_IDX) begin
            case (idx_i[3:0])
                `PIRQVM_EXC_STACK: begin
                    cls_o = PIRQVM_CLS_NONE;
                end
                `PIRQVM_EXC_RESET: begin
                    prio_o = `PIRQVM_PRIO_RESET;
                    cls_o = PIRQVM_CLS_FIXED;
                end
                `PIRQVM_EXC_NMI: begin
                    prio_o = `PIRQVM_PRIO_NMI;
                    cls_o = PIRQVM_CLS_FIXED;
                end
                `PIRQVM_EXC_HARD_FAULT: begin
                    prio_o = `PIRQVM_PRIO_HARD_FAULT;
                    cls_o = PIRQVM_CLS_FIXED;
                end
                `PIRQVM_EXC_SUPERVISOR_CALL: begin
                    prio_o = `PIRQVM_PRIO_SUPERVISOR_CALL;
                    cls_o = PIRQVM_CLS_SETTABLE;
                end
                `PIRQVM_EXC_PENDSRV: begin
                    prio_o = `PIRQVM_PRIO_PENDSRV;
                    cls_o = PIRQVM_CLS_SETTABLE;
                end
                `PIRQVM_EXC_SYSTICK: begin
                    prio_o = `PIRQVM_PRIO_SYSTICK;
                    cls_o = PIRQVM_CLS_SETTABLE;
                end
                default: begin
                    rsvd_o = 1'b1;
                end
            endcase
        end else if (idx_i < `PIRQVM_IDX_LIMIT) begin
            if (line == `PIRQVM_LN_RADIO_5) begin
                cls_o = PIRQVM_CLS_CRITICAL;
            end else begin
                cls_o = PIRQVM_CLS_SETTABLE;
            end
            rsvd_o = rsvd_mask[line];
        end else begin
            rsvd_o = 1'b1;
        end
    end
endmodule

/* verification/pirqvm_nested_vector_irq_ctrl_model.sv */
// Far-side interrupt controller model: latches pending user lines
module pirqvm_irq_ctrl_model
    import pirqvm_pkg::*;
(
    input wire logic clk_sys_i, // System clock
    input wire logic srst_i, // Synchronous reset, active high
    input wire logic [31:0] user_irq_i, // User lines from the router
    input wire logic crit_irq_i, // Critical radio line
    input wire logic clr_i, // Clear all pending lines
    output logic [31:0] pend_o, // Lines seen active since last clear
    output logic crit_seen_o // Critical line seen since last clear
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] pend_r;
    logic [31:0] pend_nxt;
    logic crit_r;
    logic crit_nxt;

    always_comb begin
        pend_nxt = clr_i ? 32'h0000_0000 : (pend_r | user_irq_i);
        crit_nxt = clr_i ? 1'b0 : (crit_r | crit_irq_i);
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pend_r <= 32'h0000_0000;
            crit_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
            crit_r <= crit_nxt;
        end
    end

    assign pend_o = pend_r;
    assign crit_seen_o = crit_r;
endmodule

/* verification/test_peripheral_irq_vector_map.sv */
// Self-checking testbench for the peripheral interrupt vector map
`define CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH t=%0t %s", $time, msg); end end
module test_peripheral_irq_vector_map
    import pirqvm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        pirqvm_idx_type idx;
        pirqvm_addr_type addr;
        pirqvm_prio_type prio;
        pirqvm_class_type cls;
        logic rsvd;
    } pirqvm_exp_type;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [15:0] periph = 16'h0000;
    logic vec_req = 1'b0;
    pirqvm_idx_type vec_idx = 6'h00;
    logic clr = 1'b0;
    logic [31:0] user_irq_o;
    logic crit_irq_o;
    logic vec_valid_o;
    pirqvm_addr_type vec_addr_o;
    pirqvm_prio_type vec_prio_o;
    pirqvm_class_type vec_cls_o;
    logic vec_rsvd_o;
    logic [31:0] pend;
    logic crit_seen;
    int miscompares = 0;
    int n_compared = 0;
    int line_of[16] = '{0, 1, 4, 5, 6, 7, 13, 14, 15, 17, 18, 19, 20, 21, 22, 23};
    pirqvm_exp_type tab[16] = '{
        '{6'h00, 8'h00, 4'h0, PIRQVM_CLS_NONE, 1'b0}, '{6'h01, 8'h04, 4'hd, PIRQVM_CLS_FIXED, 1'b0},
        '{6'h02, 8'h08, 4'he, PIRQVM_CLS_FIXED, 1'b0}, '{6'h03, 8'h0c, 4'hf, PIRQVM_CLS_FIXED, 1'b0},
        '{6'h05, 8'h14, 4'h0, PIRQVM_CLS_NONE, 1'b1}, '{6'h0b, 8'h2c, 4'h3, PIRQVM_CLS_SETTABLE, 1'b0},
        '{6'h0c, 8'h30, 4'h0, PIRQVM_CLS_NONE, 1'b1}, '{6'h0e, 8'h38, 4'h5, PIRQVM_CLS_SETTABLE, 1'b0},
        '{6'h0f, 8'h3c, 4'h6, PIRQVM_CLS_SETTABLE, 1'b0}, '{6'h10, 8'h40, 4'h0, PIRQVM_CLS_SETTABLE, 1'b0},
        '{6'h12, 8'h48, 4'h0, PIRQVM_CLS_SETTABLE, 1'b1}, '{6'h16, 8'h58, 4'h0, PIRQVM_CLS_CRITICAL, 1'b0},
        '{6'h27, 8'h9c, 4'h0, PIRQVM_CLS_SETTABLE, 1'b0}, '{6'h28, 8'ha0, 4'h0, PIRQVM_CLS_SETTABLE, 1'b1},
        '{6'h2f, 8'hbc, 4'h0, PIRQVM_CLS_SETTABLE, 1'b1}, '{6'h30, 8'hc0, 4'h0, PIRQVM_CLS_NONE, 1'b1}};

    pirqvm_top pirqvm_top_i (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .gpio_irq_i(periph[0]), .flash_irq_i(periph[1]), .uart_irq_i(periph[2]),
        .spi_irq_i(periph[3]), .radio_irq_i(periph[4]), .wdog_irq_i(periph[5]),
        .adc_irq_i(periph[6]), .i2c2_irq_i(periph[7]), .i2c1_irq_i(periph[8]),
        .multifunction_timer_one_a_irq_i(periph[9]),
        .multifunction_timer_one_b_irq_i(periph[10]),
        .multifunction_timer_two_a_irq_i(periph[11]),
        .multifunction_timer_two_b_irq_i(periph[12]),
        .rtc_irq_i(periph[13]), .pkacc_irq_i(periph[14]),
        .dma_irq_i(periph[15]), .vec_req_i(vec_req), .vec_idx_i(vec_idx),
        .user_irq_o(user_irq_o), .crit_irq_o(crit_irq_o), .vec_valid_o(vec_valid_o),
        .vec_addr_o(vec_addr_o), .vec_prio_o(vec_prio_o), .vec_cls_o(vec_cls_o),
        .vec_rsvd_o(vec_rsvd_o)
    );

    pirqvm_irq_ctrl_model pirqvm_irq_ctrl_model_i (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .user_irq_i(user_irq_o),
        .crit_irq_i(crit_irq_o), .clr_i(clr), .pend_o(pend), .crit_seen_o(crit_seen)
    );

    always #50 clk_sys_i = ~clk_sys_i;

    task automatic wrap_up();
        $display("Counts: compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Every output must read zero while reset is applied
    task automatic check_idle(input string what);
        `CHK(user_irq_o, 32'h0000_0000, what)
        `CHK(crit_irq_o, 1'b0, what)
        `CHK(vec_valid_o, 1'b0, what)
        `CHK(vec_rsvd_o, 1'b0, what)
        `CHK(vec_addr_o, 8'h00, what)
        `CHK(vec_prio_o, 4'h0, what)
        `CHK(vec_cls_o, PIRQVM_CLS_NONE, what)
    endtask

    task automatic test_routing();
        logic [31:0] exp_all;
        exp_all = 32'h0000_0000;
        for (int k = 0; k < 16; k++) begin
            periph = 16'h0001 << k;
            @(negedge clk_sys_i);
            `CHK(user_irq_o, 32'h0000_0001 << line_of[k], "single source line")
            `CHK(crit_irq_o, (line_of[k] == 6), "critical follows radio")
            exp_all[line_of[k]] = 1'b1;
        end
        periph = 16'hffff;
        @(negedge clk_sys_i);
        `CHK(user_irq_o, exp_all, "all sources, reserved quiet")
        periph = 16'h0000;
        @(negedge clk_sys_i);
        `CHK(user_irq_o, 32'h0000_0000, "lines follow release")
        `CHK(pend, exp_all, "controller saw only used lines")
        `CHK(crit_seen, 1'b1, "controller saw critical line")
        clr = 1'b1;
        @(negedge clk_sys_i);
        clr = 1'b0;
        $display("Test routing done");
    endtask

    task automatic test_lookup();
        vec_req = 1'b1;
        vec_idx = tab[0].idx;
        for (int k = 0; k < 16; k++) begin
            @(negedge clk_sys_i);
            `CHK(vec_valid_o, 1'b1, "answer valid")
            `CHK(vec_addr_o, tab[k].addr, "vector offset")
            `CHK(vec_prio_o, tab[k].prio, "default priority")
            `CHK(vec_cls_o, tab[k].cls, "priority class")
            `CHK(vec_rsvd_o, tab[k].rsvd, "reserved flag")
            if (k < 15) begin
                vec_idx = tab[k + 1].idx;
            end else begin
                vec_req = 1'b0;
            end
        end
        @(negedge clk_sys_i);
        `CHK(vec_valid_o, 1'b0, "single answer per strobe")
        `CHK(vec_rsvd_o, 1'b1, "answer holds")
        $display("Test lookup done");
    endtask

    task automatic test_mid_reset();
        periph = 16'hffff;
        vec_req = 1'b1;
        vec_idx = 6'h16;
        @(negedge clk_sys_i);
        `CHK(crit_irq_o, 1'b1, "critical before reset")
        `CHK(vec_cls_o, PIRQVM_CLS_CRITICAL, "radio class before reset")
        srst_i = 1'b1;
        @(negedge clk_sys_i);
        check_idle("reset clears outputs");
        srst_i = 1'b0;
        periph = 16'h0004;
        vec_idx = 6'h01;
        @(negedge clk_sys_i);
        `CHK(user_irq_o, 32'h0000_0010, "request right after release")
        `CHK(vec_valid_o, 1'b1, "strobe right after release")
        `CHK(vec_prio_o, 4'hd, "reset handler priority")
        periph = 16'h0000;
        vec_req = 1'b0;
        @(negedge clk_sys_i);
        `CHK(user_irq_o, 32'h0000_0000, "line released")
        `CHK(vec_valid_o, 1'b0, "one answer after release")
        $display("Test mid reset done");
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys_i);
        miscompares++;
        $display("MISMATCH t=%0t run limit reached", $time);
        wrap_up();
    end

    initial begin
        repeat (5) @(negedge clk_sys_i);
        check_idle("after reset");
        srst_i = 1'b0;
        test_routing();
        test_lookup();
        test_mid_reset();
        wrap_up();
    end
endmodule
